//--- verilog/diag_count_pkg.sv
// constants shared by the receive diagnostic counter block
package diag_count_pkg;

  // ==========================================================
  // bus shape
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_COUNT_CTRL      = 8'h00;
  localparam logic [7:0] OFS_FCS_ERROR_COUNT = 8'h0a;
  localparam logic [7:0] OFS_FILTER_REJECT   = 8'h0c;
  localparam logic [7:0] OFS_RX_OVERRUN      = 8'h0e;
  localparam logic [7:0] OFS_INT_STATUS      = 8'h20;
  localparam logic [7:0] OFS_INT_ENABLE      = 8'h22;
  localparam logic [7:0] OFS_INT_CLEAR       = 8'h24;

  // ==========================================================
  // fields and reset values
  localparam int unsigned BIT_COUNT_ENABLE = 0;
  localparam int unsigned CNT_W_DEF        = 12;
  localparam int unsigned NUM_CNT          = 3;
  localparam int unsigned IDX_FCS          = 0;
  localparam int unsigned IDX_FFR          = 1;
  localparam int unsigned IDX_OVR          = 2;
  localparam logic        RST_COUNT_ENABLE = 1'b0;
  localparam logic [2:0]  RST_INT_STATUS   = 3'h0;
  localparam logic [2:0]  RST_INT_ENABLE   = 3'h0;
  localparam logic [15:0] RST_READ_DATA    = 16'h0000;

endpackage : diag_count_pkg

//--- verilog/count_link_if.sv
// signals between the register block and one event counter
`timescale 1ns/1ps
interface count_link_if #(parameter int unsigned CNT_W = 12);
  logic             ev;
  logic             en;
  logic [CNT_W-1:0] count;
  logic             wrap;

  modport ctrl
  (
    output ev,
    output en,
    input  count,
    input  wrap
  );

  modport cnt
  (
    input  ev,
    input  en,
    output count,
    output wrap
  );
endinterface : count_link_if

//--- verilog/event_counter.sv
// one gated, wrapping event counter
`timescale 1ns/1ps
module event_counter #(parameter int unsigned CNT_W = 12)
(
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  count_link_if.cnt   link
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // ==========================================================
  // next count
  always_comb
  begin
    count_nxt = count_r;
    if (link.ev && link.en)
    begin
      count_nxt = count_r + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  assign link.count = count_r;
  assign link.wrap  = link.ev && link.en && (count_r == {CNT_W{1'b1}});

  // ==========================================================
  // checks
  property p_gated_hold;
    @(posedge ref_clk) disable iff (!resetn)
      !(link.ev && link.en) |=> (count_r == $past(count_r));
  endproperty
  a_gated_hold: assert property (p_gated_hold)
    else $error("counter moved without an enabled event");

  property p_wrap_zero;
    @(posedge ref_clk) disable iff (!resetn)
      link.wrap |=> (count_r == '0);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("counter did not wrap to zero");

endmodule : event_counter

//--- verilog/rx_diag_error_counters.sv
// receive diagnostic error counters with register port and interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module rx_diag_error_counters
  import diag_count_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF
)
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              rx_bad_check_event,
  input  wire logic              frame_filter_reject_event,
  input  wire logic              rx_overflow_event,
  output logic                   diag_counting_enable,
  output logic                   irq
);

  // ==========================================================
  // parameter check
  generate
    if (CNT_W < 1 || CNT_W > DATA_W)
    begin : g_bad_width
      $error("counter width must lie between 1 and the data width");
    end
  endgenerate

  // ==========================================================
  // state
  logic                ctrl_enable_r;
  logic                ctrl_enable_nxt;
  logic [NUM_CNT-1:0]  int_status_r;
  logic [NUM_CNT-1:0]  int_status_nxt;
  logic [NUM_CNT-1:0]  int_enable_r;
  logic [NUM_CNT-1:0]  int_enable_nxt;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic [NUM_CNT-1:0]  ev_vec;
  logic [NUM_CNT-1:0]  wrap_vec;
  logic [CNT_W-1:0]    counts [NUM_CNT];

  assign ev_vec[IDX_FCS] = rx_bad_check_event;
  assign ev_vec[IDX_FFR] = frame_filter_reject_event;
  assign ev_vec[IDX_OVR] = rx_overflow_event;

  // ==========================================================
  // counters
  count_link_if #(.CNT_W(CNT_W)) links [NUM_CNT] ();

  generate
    for (genvar i = 0; i < NUM_CNT; i++)
    begin : g_cnt
      // each cycle an event is high is one frame, so overrun discards count one by one
      assign links[i].ev  = ev_vec[i];
      assign links[i].en  = ctrl_enable_r;
      assign counts[i]    = links[i].count;
      assign wrap_vec[i]  = links[i].wrap;

      event_counter #(.CNT_W(CNT_W)) u_cnt
      (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .link    (links[i].cnt)
      );
    end
  endgenerate

  // ==========================================================
  // register writes, status and read data
  always_comb
  begin
    ctrl_enable_nxt = ctrl_enable_r;
    int_enable_nxt  = int_enable_r;
    int_status_nxt  = int_status_r;
    rdata_nxt       = RST_READ_DATA;
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_COUNT_CTRL: ctrl_enable_nxt = reg_wdata[BIT_COUNT_ENABLE];
        OFS_INT_ENABLE: int_enable_nxt  = reg_wdata[NUM_CNT-1:0];
        OFS_INT_CLEAR:  int_status_nxt  = int_status_r & ~reg_wdata[NUM_CNT-1:0];
        default:        ;
      endcase
    end
    // a wrap in the clearing cycle survives
    int_status_nxt = int_status_nxt | wrap_vec;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_COUNT_CTRL:
          rdata_nxt[BIT_COUNT_ENABLE] = ctrl_enable_r;
        OFS_FCS_ERROR_COUNT:
          rdata_nxt = DATA_W'(counts[IDX_FCS]);
        OFS_FILTER_REJECT:
          rdata_nxt = DATA_W'(counts[IDX_FFR]);
        OFS_RX_OVERRUN:
          rdata_nxt = DATA_W'(counts[IDX_OVR]);
        OFS_INT_STATUS:
          rdata_nxt = DATA_W'(int_status_r);
        OFS_INT_ENABLE:
          rdata_nxt = DATA_W'(int_enable_r);
        default:
          rdata_nxt = RST_READ_DATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_enable_r <= RST_COUNT_ENABLE;
      int_enable_r  <= RST_INT_ENABLE;
      int_status_r  <= RST_INT_STATUS;
      rdata_r       <= RST_READ_DATA;
    end
    else
    begin
      ctrl_enable_r <= ctrl_enable_nxt;
      int_enable_r  <= int_enable_nxt;
      int_status_r  <= int_status_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  assign reg_rdata            = rdata_r;
  assign diag_counting_enable = ctrl_enable_r;
  assign irq                  = |(int_status_r & int_enable_r);

  // ==========================================================
  // checks
  property p_fcs_inc;
    @(posedge ref_clk) disable iff (!resetn)
      (rx_bad_check_event && ctrl_enable_r)
        |=> (counts[IDX_FCS] == CNT_W'($past(counts[IDX_FCS]) + 1'b1));
  endproperty
  a_fcs_inc: assert property (p_fcs_inc)
    else $error("frame check count did not step by one");

  property p_fcs_only_on_event;
    @(posedge ref_clk) disable iff (!resetn)
      !rx_bad_check_event |=> (counts[IDX_FCS] == $past(counts[IDX_FCS]));
  endproperty
  a_fcs_only_on_event: assert property (p_fcs_only_on_event)
    else $error("frame check count moved with no event");

  property p_ffr_inc;
    @(posedge ref_clk) disable iff (!resetn)
      (frame_filter_reject_event && ctrl_enable_r)
        |=> (counts[IDX_FFR] == CNT_W'($past(counts[IDX_FFR]) + 1'b1));
  endproperty
  a_ffr_inc: assert property (p_ffr_inc)
    else $error("filter reject count did not step by one");

  property p_ovr_inc;
    @(posedge ref_clk) disable iff (!resetn)
      (rx_overflow_event && ctrl_enable_r)
        |=> (counts[IDX_OVR] == CNT_W'($past(counts[IDX_OVR]) + 1'b1));
  endproperty
  a_ovr_inc: assert property (p_ovr_inc)
    else $error("overflow count did not step by one");

  sequence s_two_discards;
    (rx_overflow_event && ctrl_enable_r && !reg_wr) [*2];
  endsequence

  property p_ovr_every_discard;
    @(posedge ref_clk) disable iff (!resetn)
      s_two_discards |=> (counts[IDX_OVR] == CNT_W'($past(counts[IDX_OVR], 2) + 2'd2));
  endproperty
  a_ovr_every_discard: assert property (p_ovr_every_discard)
    else $error("overflow count missed a discarded frame");

  property p_disabled_frozen;
    @(posedge ref_clk) disable iff (!resetn)
      !ctrl_enable_r |=> (counts[IDX_FCS] == $past(counts[IDX_FCS]))
        && (counts[IDX_FFR] == $past(counts[IDX_FFR]))
        && (counts[IDX_OVR] == $past(counts[IDX_OVR]));
  endproperty
  a_disabled_frozen: assert property (p_disabled_frozen)
    else $error("a counter moved while counting was disabled");

  property p_read_count;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_RX_OVERRUN)
        |=> (reg_rdata == DATA_W'($past(counts[IDX_OVR])))
        && (reg_rdata[15:12] == 4'h0);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("overflow count read back wrong");

  property p_read_undisturbed;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_rd && !rx_bad_check_event) ##1 !rx_bad_check_event
        |=> (counts[IDX_FCS] == $past(counts[IDX_FCS], 2));
  endproperty
  a_read_undisturbed: assert property (p_read_undisturbed)
    else $error("a read changed a count");

  property p_fcs_wrap;
    @(posedge ref_clk) disable iff (!resetn)
      (rx_bad_check_event && ctrl_enable_r && counts[IDX_FCS] == {CNT_W{1'b1}})
        |=> (counts[IDX_FCS] == '0) && int_status_r[IDX_FCS];
  endproperty
  a_fcs_wrap: assert property (p_fcs_wrap)
    else $error("frame check count did not wrap or flag it");

  property p_set_beats_clear;
    @(posedge ref_clk) disable iff (!resetn)
      (wrap_vec[IDX_OVR] && reg_wr && reg_addr == OFS_INT_CLEAR)
        |=> int_status_r[IDX_OVR];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("wrap lost against a status clear");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!resetn)
      (int_status_r[IDX_FFR] && int_enable_r[IDX_FFR]) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with an enabled status bit set");

  property p_rdata_one_cycle;
    @(posedge ref_clk) disable iff (!resetn)
      !reg_rd |=> (reg_rdata == RST_READ_DATA);
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("read data stood outside its cycle");

  property p_ffr_only_on_event;
    @(posedge ref_clk) disable iff (!resetn)
      !frame_filter_reject_event |=> (counts[IDX_FFR] == $past(counts[IDX_FFR]));
  endproperty
  a_ffr_only_on_event: assert property (p_ffr_only_on_event)
    else $error("filter reject count moved with no event");

  property p_ovr_only_on_event;
    @(posedge ref_clk) disable iff (!resetn)
      !rx_overflow_event |=> (counts[IDX_OVR] == $past(counts[IDX_OVR]));
  endproperty
  a_ovr_only_on_event: assert property (p_ovr_only_on_event)
    else $error("overflow count moved with no event");

  property p_read_fcs;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_FCS_ERROR_COUNT)
        |=> (reg_rdata == DATA_W'($past(counts[IDX_FCS])))
        && (reg_rdata[15:12] == 4'h0);
  endproperty
  a_read_fcs: assert property (p_read_fcs)
    else $error("frame check count read back wrong");

  property p_read_ffr;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_FILTER_REJECT)
        |=> (reg_rdata == DATA_W'($past(counts[IDX_FFR])))
        && (reg_rdata[15:12] == 4'h0);
  endproperty
  a_read_ffr: assert property (p_read_ffr)
    else $error("filter reject count read back wrong");

  property p_enable_write;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == OFS_COUNT_CTRL)
        |=> (diag_counting_enable == $past(reg_wdata[BIT_COUNT_ENABLE]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("counting enable did not follow its write");

  property p_disabled_no_wrap;
    @(posedge ref_clk) disable iff (!resetn)
      !ctrl_enable_r |-> (wrap_vec == '0);
  endproperty
  a_disabled_no_wrap: assert property (p_disabled_no_wrap)
    else $error("a wrap was flagged while counting was disabled");

  sequence s_ffr_wrap_enabled;
    wrap_vec[IDX_FFR] && int_enable_r[IDX_FFR]
      && !(reg_wr && reg_addr == OFS_INT_ENABLE);
  endsequence

  property p_wrap_raises_irq;
    @(posedge ref_clk) disable iff (!resetn)
      s_ffr_wrap_enabled |=> (int_status_r[IDX_FFR] && irq);
  endproperty
  a_wrap_raises_irq: assert property (p_wrap_raises_irq)
    else $error("a wrap did not raise the interrupt");

  property p_status_clear;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == OFS_INT_CLEAR && reg_wdata[IDX_FCS] && !wrap_vec[IDX_FCS])
        |=> !int_status_r[IDX_FCS];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit survived its clear");

endmodule : rx_diag_error_counters

//--- tb/tb.sv
// self-checking bench for the receive diagnostic error counters
`timescale 1ns/1ps
`define CHK(got, exp, msg) check_val(got, exp, msg)
module tb
  import diag_count_pkg::*;
;
  logic              ref_clk;
  logic              resetn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [2:0]        ev;
  logic              diag_counting_enable;
  logic              irq;
  logic [11:0]       cnt_m [3];
  logic              en_m;
  logic [2:0]        ie_m;
  logic [2:0]        st_m;
  logic [DATA_W-1:0] exp_rd;
  logic [31:0]       seed;
  int                miscompares;
  int                compares;

  rx_diag_error_counters #(.CNT_W(CNT_W_DEF)) dut
  (
    .ref_clk                   (ref_clk),
    .resetn                    (resetn),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .rx_bad_check_event        (ev[IDX_FCS]),
    .frame_filter_reject_event (ev[IDX_FFR]),
    .rx_overflow_event         (ev[IDX_OVR]),
    .diag_counting_enable      (diag_counting_enable),
    .irq                       (irq)
  );

  // ==========================================================
  // expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [DATA_W-1:0] exp_read(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_COUNT_CTRL:      exp_read = {15'h0000, en_m};
      OFS_FCS_ERROR_COUNT: exp_read = {4'h0, cnt_m[IDX_FCS]};
      OFS_FILTER_REJECT:   exp_read = {4'h0, cnt_m[IDX_FFR]};
      OFS_RX_OVERRUN:      exp_read = {4'h0, cnt_m[IDX_OVR]};
      OFS_INT_STATUS:      exp_read = {13'h0000, st_m};
      OFS_INT_ENABLE:      exp_read = {13'h0000, ie_m};
      default:             exp_read = 16'h0000;
    endcase
  endfunction : exp_read

  function automatic logic [2:0] wraps();
    for (int i = 0; i < 3; i++)
      wraps[i] = en_m && ev[i] && (cnt_m[i] == 12'hfff);
  endfunction : wraps

  function automatic logic [ADDR_W-1:0] pick(input logic [2:0] k, input logic [7:0] raw);
    case (k)
      3'h0:    pick = OFS_COUNT_CTRL;
      3'h1:    pick = OFS_FCS_ERROR_COUNT;
      3'h2:    pick = OFS_FILTER_REJECT;
      3'h3:    pick = OFS_RX_OVERRUN;
      3'h4:    pick = OFS_INT_STATUS;
      3'h5:    pick = OFS_INT_ENABLE;
      3'h6:    pick = OFS_INT_CLEAR;
      default: pick = raw;
    endcase
  endfunction : pick

  // reference model of the register file, clocked beside the design
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_m <= 1'b0;
      ie_m <= 3'h0;
      st_m <= 3'h0;
      exp_rd <= 16'h0000;
      for (int i = 0; i < 3; i++)
        cnt_m[i] <= 12'h000;
    end
    else
    begin
      exp_rd <= reg_rd ? exp_read(reg_addr) : 16'h0000;
      if (reg_wr && reg_addr == OFS_COUNT_CTRL)
        en_m <= reg_wdata[0];
      if (reg_wr && reg_addr == OFS_INT_ENABLE)
        ie_m <= reg_wdata[2:0];
      // a wrap in the same cycle as a clear keeps its status bit
      st_m <= (st_m & ~((reg_wr && reg_addr == OFS_INT_CLEAR) ? reg_wdata[2:0] : 3'h0))
              | wraps();
      for (int i = 0; i < 3; i++)
        if (en_m && ev[i])
          cnt_m[i] <= cnt_m[i] + 12'h001;
    end
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_val

  always @(negedge ref_clk)
  begin
    `CHK(reg_rdata, exp_rd, "read data");
    `CHK({15'h0000, irq}, {15'h0000, |(st_m & ie_m)}, "irq");
    `CHK({15'h0000, diag_counting_enable}, {15'h0000, en_m}, "enable");
  end

  // ==========================================================
  // stimulus
  task automatic step(input logic w, input logic r, input logic [7:0] a,
                      input logic [15:0] d, input logic [2:0] e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    ev <= e;
    @(posedge ref_clk);
  endtask : step

  task automatic run_random(input int n, input logic allow_wr);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      if (seed[5:3] < 3'h3)
        step(1'b0, 1'b1, pick(seed[8:6], seed[23:16]), 16'h0000, seed[2:0]);
      else if (seed[5:3] == 3'h3 && allow_wr)
        step(1'b1, 1'b0, pick(seed[8:6], seed[23:16]), seed[31:16], seed[2:0]);
      else
        step(1'b0, 1'b0, 8'h00, 16'h0000, seed[2:0]);
    end
  endtask : run_random

  task automatic read_all();
    for (int k = 0; k < 8; k++)
      step(1'b0, 1'b1, pick(k[2:0], 8'h31), 16'h0000, 3'h0);
  endtask : read_all

  task tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish;
  end

  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    ev = 3'h0;
    seed = 32'hd0bb;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    read_all();
    step(1'b1, 1'b0, OFS_FCS_ERROR_COUNT, 16'hffff, 3'h0);
    step(1'b0, 1'b1, OFS_FCS_ERROR_COUNT, 16'h0000, 3'h0);
    $display("test reset_values done");
    run_random(300, 1'b0);
    read_all();
    $display("test disabled_counting done");
    step(1'b1, 1'b0, OFS_COUNT_CTRL, 16'h0001, 3'h0);
    run_random(800, 1'b1);
    $display("test random_traffic done");
    step(1'b1, 1'b0, OFS_COUNT_CTRL, 16'h0001, 3'h0);
    step(1'b1, 1'b0, OFS_INT_ENABLE, 16'h0007, 3'h0);
    // every cycle is one discarded frame while the overrun lasts; cnt_m still holds
    // the count of the cycle just ended, so ffe here means the next edge wraps and
    // the status clear lands on that very edge
    for (int i = 0; i < 4100; i++)
      if (cnt_m[IDX_OVR] == 12'hffe)
        step(1'b1, 1'b0, OFS_INT_CLEAR, 16'h0004, 3'h7);
      else
        step(1'b0, 1'b0, 8'h00, 16'h0000, 3'h7);
    read_all();
    step(1'b1, 1'b0, OFS_INT_CLEAR, 16'h0005, 3'h0);
    read_all();
    $display("test wrap_and_interrupt done");
    resetn <= 1'b0;
    step(1'b0, 1'b0, 8'h00, 16'h0000, 3'h7);
    resetn <= 1'b1;
    read_all();
    $display("test mid_run_reset done");
    tally_and_finish;
  end
endmodule : tb
